/* File: verilog/evpu_defines.svh */
/*
 * Constants of the exception vector priority unit: register indices and
 * byte addresses, field positions, reset values and vector slot numbers.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef EVPU_DEFINES_SVH
`define EVPU_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and APB byte addresses (index times four)
// ----------------------------------------------------------------------
`define IDX_TEST_CONTROL    6'h15
`define IDX_TEST_FORCE_BANK 6'h16
`define IDX_PROMOTE_SELECT  6'h1F
`define ADDR_TEST_CONTROL    {`IDX_TEST_CONTROL, 2'b00}
`define ADDR_TEST_FORCE_BANK {`IDX_TEST_FORCE_BANK, 2'b00}
`define ADDR_PROMOTE_SELECT  {`IDX_PROMOTE_SELECT, 2'b00}

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BIT_OVERRIDE        4
`define RESET_TEST_CONTROL  8'h00
`define RESET_PROMOTE       8'hF2
`define PROMOTE_LIMIT       8'hF2
`define BANK_TOP            4'hF
`define BANK_TOP_MASK       8'h07

// ----------------------------------------------------------------------
// Vector slots: address is 0xFF00 plus twice the slot number
// ----------------------------------------------------------------------
`define VECTOR_PAGE         8'hFF
`define SLOT_EXT_REQUEST    7'd121
`define SLOT_X_CLASS        7'd122
`define SLOT_SOFTWARE       7'd123
`define SLOT_TRAP           7'd124
`define SLOT_WATCHDOG       7'd125
`define SLOT_CLOCK_MONITOR  7'd126
`define SLOT_SYSTEM_RESET   7'd127
`define NUM_MASKABLE_SLOTS  123

`endif

/* File: verilog/evpu_pkg.sv */
/*
 * Types shared by the exception vector priority unit.
 * Assumes nothing of its surroundings.
 */
package evpu_pkg;

    // Slot number of a vector (address bits 7:1)
    typedef logic [6:0] vector_slot_t;

    // CPU side state that qualifies servicing and test access
    typedef struct packed {
        logic i_mask;        // Maskable I class blocked in condition register
        logic x_mask;        // X class blocked in condition register
        logic special_mode;  // Chip in a special mode
    } cpu_state_t;

    // Non-maskable exception requests
    typedef struct packed {
        logic system_reset;         // Power-on or system reset
        logic clock_monitor_reset;  // Clock monitor reset
        logic watchdog_reset;       // Watchdog reset
        logic illegal_opcode;       // Unimplemented opcode trap
        logic software_interrupt;   // Software instruction or background debug
    } fixed_req_t;

endpackage

/* File: verilog/exception_vector_priority_unit.sv */
/*
 * Exception vector priority unit: collects exception requests, decodes
 * priority, answers CPU vector requests, flags pending interrupts, raises
 * wake-up, and holds test and promotion registers on an APB slave.
 * Assumes all request inputs and CPU state come from core-clock logic,
 * and that the external bus block delivers the pin levels active high.
 */
// The implementer's own choice: the APB register port.
// Function
// - Two to 122 maskable I vectors at 0xFF00 through 0xFFF2.
// - One X-class vector at 0xFFF4.
// - Software or debug request vector at 0xFFF6, unmaskable.
// - Illegal opcode trap vector at 0xFFF8, unmaskable.
// - Three reset vectors 0xFFFA to 0xFFFE.
// - On vector request, give highest priority exception vector.
// - Flag the CPU while any valid request is pending.
// - Inhibit inputs block I and X class servicing.
// - Wake on qualifying interrupt, or X pin even when masked.
// - Wake-up detection registered on the core clock for all I and X sources.
// - Promotion selection makes one I source top of I class.
// - Override clear: test writes ignored, reads show live inputs.
// - Override set: decoder fed from test registers, not inputs.
// - Requests pending when override sets stay until overwritten.
// - Four-bit select chooses bank, equals vector upper nibble.
// - Bank reads only in special mode, otherwise zero.
// - Bank writes need special mode, override and I mask.
// - Bank bit n forces vector with low nibble 2n.
// - One eight-bit bank per eight vectors, one shared address.
// - Bank F only bits 2:0, bits 7:3 read zero.
// - Unimplemented bank: writes dropped, reads zero.
// - Promotion value above 0xF2 or unimplemented leaves 0xFFF2 top.
// - Fixed order: resets, trap, software, X, external, then others.
// - Vanished source gives last valid vector; none ever gives software.
`include "evpu_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module exception_vector_priority_unit
    import evpu_pkg::*;
#(
    parameter int NUM_PERIPH = 121          // Peripheral I sources, 1 to 121
)
(
    input  wire logic                  clock,              // Core clock
    input  wire logic                  reset,              // Synchronous reset
    input  wire logic [7:0]            paddr,              // APB address
    input  wire logic                  psel,               // APB select
    input  wire logic                  penable,            // APB enable
    input  wire logic                  pwrite,             // APB direction
    input  wire logic [31:0]           pwdata,             // APB write data
    output logic      [31:0]           prdata,             // APB read data
    output logic                       pready,             // APB ready
    output logic                       pslverr,            // APB error
    input  wire logic [NUM_PERIPH-1:0] periph_req,         // Peripheral I requests
    input  wire logic                  ext_request_pin,    // External request level
    input  wire logic                  x_class_request_pin,// X-class pin level
    input  wire fixed_req_t            fixed_req,          // Unmaskable requests
    input  wire cpu_state_t            cpu_state,          // Masks and mode
    input  wire logic                  i_inhibit,          // Block I class
    input  wire logic                  x_inhibit,          // Block X class
    input  wire logic                  vector_request,     // CPU asks for vector
    output logic      [15:0]           vector_addr,        // Vector onto address bus
    output logic                       vector_valid,       // Vector strobe
    output logic                       interrupt_pending,  // Valid request pending
    output logic                       wake_request        // Stop or wait wake-up
);

    // ------------------------------------------------------------------
    // Implemented slots and bank decoding
    // ------------------------------------------------------------------

    localparam int NM = `NUM_MASKABLE_SLOTS;

    // Slot implemented when it has a peripheral or is a pin source
    function automatic logic slot_impl(input int s);
        return (s < NUM_PERIPH) || (s == 121) || (s == 122);
    endfunction

    // Bits of a bank that exist; bank F is cut to bits 2:0
    function automatic logic [7:0] bank_mask(input logic [3:0] b);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 8; k++)
            if ((8 * int'(b) + k) < NM)
                m[k] = slot_impl(8 * int'(b) + k);
        if (b == `BANK_TOP)
            m = m & `BANK_TOP_MASK;
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    logic          override;          // Test override enable
    logic [3:0]    bank_select;       // Test bank select
    logic [7:1]    promote_select;    // Promotion select
    logic [NM-1:0] test_force;        // Forced requests
    logic [NM-1:0] live_req;          // Real maskable inputs
    logic [NM-1:0] decoder_req;       // Requests seen by the decoder
    logic [15:0]   last_vector;       // Last valid vector of sequence
    logic [31:0]   next_prdata;
    logic          next_pslverr;
    logic [7:0]    bank_live;
    logic [7:0]    bank_forced;

    wire logic setup       = psel & ~penable;
    wire logic write_done  = psel & penable & pready & pwrite;
    wire logic hit_control = paddr == `ADDR_TEST_CONTROL;
    wire logic hit_bank    = paddr == `ADDR_TEST_FORCE_BANK;
    wire logic hit_promote = paddr == `ADDR_PROMOTE_SELECT;
    wire logic [7:0] sel_mask = bank_mask(bank_select);

    // Gather maskable inputs into slot order
    // slot layout
    always_comb
    begin
        live_req = '0;
        for (int s = 0; s < NUM_PERIPH; s++)
            live_req[s] = periph_req[s];
        live_req[`SLOT_EXT_REQUEST] = ext_request_pin;
        live_req[`SLOT_X_CLASS]     = x_class_request_pin;
    end

    assign decoder_req = override ? test_force : live_req;

    // Bank views for reads
    // bit n is slot 8*select+n
    always_comb
    begin
        bank_live   = 8'h00;
        bank_forced = 8'h00;
        for (int k = 0; k < 8; k++)
            if ((8 * int'(bank_select) + k) < NM)
            begin
                bank_live[k]   = live_req[8 * int'(bank_select) + k];
                bank_forced[k] = test_force[8 * int'(bank_select) + k];
            end
        bank_live   = bank_live & sel_mask;
        bank_forced = bank_forced & sel_mask;
    end

    // Override bit and bank select
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            override    <= 1'(`RESET_TEST_CONTROL >> `BIT_OVERRIDE);
            bank_select <= 4'(`RESET_TEST_CONTROL);
        end
        else if (write_done && hit_control)
        begin
            bank_select <= pwdata[3:0];
            // override guarded by mode and masks
            if (cpu_state.special_mode && cpu_state.i_mask && cpu_state.x_mask)
                override <= pwdata[`BIT_OVERRIDE];
        end
    end

    // Forced request store
    always_ff @(posedge clock)
    begin
        if (reset)
            test_force <= '0;
        // pending inputs carried into the store
        else if (!override)
            test_force <= live_req;
        else if (write_done && hit_bank && cpu_state.special_mode
                 && cpu_state.i_mask)
            for (int k = 0; k < 8; k++)
                if (sel_mask[k])
                    test_force[8 * int'(bank_select) + k] <= pwdata[k];
    end

    // Promotion select, writable only while I class is masked
    always_ff @(posedge clock)
    begin
        if (reset)
            promote_select <= 7'(`RESET_PROMOTE >> 1);
        else if (write_done && hit_promote && cpu_state.i_mask)
            promote_select <= pwdata[7:1];
    end

    // ------------------------------------------------------------------
    // APB read path and answer
    // ------------------------------------------------------------------

    // Read data latched in the setup cycle, zero wait states
    always_comb
    begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (hit_control)
            next_prdata[7:0] = {3'b000, override, bank_select};
        // mode and override pick the view
        else if (hit_bank && cpu_state.special_mode)
            next_prdata[7:0] = override ? bank_forced : bank_live;
        else if (hit_promote)
            next_prdata[7:0] = {promote_select, 1'b0};
        else if (!hit_bank)
            next_pslverr = 1'b1;
    end

    // APB answer registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & next_pslverr;
            prdata  <= setup ? next_prdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Priority decoder
    // ------------------------------------------------------------------

    logic         i_enabled;
    logic         x_valid;
    logic [121:0] i_valid;
    logic         any_valid;
    vector_slot_t promote_slot;
    vector_slot_t win_slot;

    assign i_enabled = ~cpu_state.i_mask & ~i_inhibit;
    assign x_valid   = decoder_req[`SLOT_X_CLASS] & ~cpu_state.x_mask & ~x_inhibit;

    // Valid I requests in implemented slots only
    always_comb
    begin
        for (int s = 0; s < 122; s++)
            i_valid[s] = decoder_req[s] & slot_impl(s) & i_enabled;
    end

    // out-of-range selection falls back to external request
    always_comb
    begin
        promote_slot = promote_select;
        if ({promote_select, 1'b0} > `PROMOTE_LIMIT || !slot_impl(int'(promote_select)))
            promote_slot = `SLOT_EXT_REQUEST;
    end

    always_comb
    begin
        win_slot = `SLOT_SOFTWARE;
        for (int s = 0; s < 122; s++)
            if (i_valid[s])
                win_slot = 7'(s);
        // promoted source tops the I class
        if (i_valid[promote_slot])
            win_slot = promote_slot;
        if (x_valid)
            win_slot = `SLOT_X_CLASS;
        if (fixed_req.software_interrupt)
            win_slot = `SLOT_SOFTWARE;
        if (fixed_req.illegal_opcode)
            win_slot = `SLOT_TRAP;
        if (fixed_req.watchdog_reset)
            win_slot = `SLOT_WATCHDOG;
        if (fixed_req.clock_monitor_reset)
            win_slot = `SLOT_CLOCK_MONITOR;
        if (fixed_req.system_reset)
            win_slot = `SLOT_SYSTEM_RESET;
    end

    assign any_valid = (|i_valid) | x_valid | (|fixed_req);

    // Remember the last valid winner
    always_ff @(posedge clock)
    begin
        if (reset)
            last_vector <= {`VECTOR_PAGE, `SLOT_SOFTWARE, 1'b0};
        // software vector until a request has been seen
        else if (any_valid)
            last_vector <= {`VECTOR_PAGE, win_slot, 1'b0};
    end

    // Vector answer, one cycle after the request
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            vector_addr  <= {`VECTOR_PAGE, `SLOT_SOFTWARE, 1'b0};
            vector_valid <= 1'b0;
        end
        else
        begin
            vector_valid <= vector_request;
            // winning vector onto the address bus
            // vanished source reuses last valid vector
            if (vector_request)
                vector_addr <= any_valid ? {`VECTOR_PAGE, win_slot, 1'b0} : last_vector;
        end
    end

    // Pending flag and wake-up
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            interrupt_pending <= 1'b0;
            wake_request      <= 1'b0;
        end
        else
        begin
            interrupt_pending <= any_valid;
            // wake from valid I and X requests, raw X pin even when masked
            wake_request <= (|i_valid) | x_valid | x_class_request_pin;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence apb_setup_read(logic hit);
        setup && !pwrite && hit;
    endsequence

    sequence apb_control_write_blocked;
        setup && pwrite && hit_control && pwdata[`BIT_OVERRIDE] && !override
            && !(cpu_state.special_mode && cpu_state.i_mask && cpu_state.x_mask) ##1 write_done;
    endsequence

    chk_vector_strobe: assert property
        (vector_valid == $past(vector_request))
        else $error("vector strobe missing after request");

    chk_reset_first: assert property
        (vector_request && fixed_req.system_reset |=> vector_addr == 16'hFFFE)
        else $error("system reset did not win");

    chk_trap_order: assert property
        (vector_request && fixed_req.illegal_opcode && !fixed_req.system_reset
         && !fixed_req.clock_monitor_reset && !fixed_req.watchdog_reset
         |=> vector_addr == 16'hFFF8)
        else $error("trap vector wrong");

    chk_pending_flag: assert property
        (fixed_req.software_interrupt |=> interrupt_pending)
        else $error("pending flag not raised");

    chk_inhibit_blocks: assert property
        (i_inhibit && x_inhibit && !(|fixed_req) |=> !interrupt_pending)
        else $error("inhibited request shown pending");

    chk_xpin_wake: assert property
        (x_class_request_pin |=> wake_request)
        else $error("X pin did not wake");

    chk_override_guard: assert property
        (apb_control_write_blocked |=> !override)
        else $error("override set outside special mode");

    chk_normal_read_zero: assert property
        (apb_setup_read(hit_bank && !cpu_state.special_mode) |=> prdata == 32'h0000_0000)
        else $error("bank read not zero in normal mode");

    chk_top_bank_bits: assert property
        (apb_setup_read(hit_bank && bank_select == `BANK_TOP) |=> prdata[7:3] == 5'b00000)
        else $error("bank F upper bits not zero");

    chk_promote_wins: assert property
        (vector_request && i_valid[promote_slot] && !x_valid && !(|fixed_req)
         |=> vector_addr == {`VECTOR_PAGE, $past(promote_slot), 1'b0})
        else $error("promoted source did not win");

    chk_swi_default: assert property
        (vector_request && !any_valid && last_vector == 16'hFFF6 |=> vector_addr == 16'hFFF6)
        else $error("default vector wrong");

endmodule

`default_nettype wire

/* File: verification/cpu_vector_model.sv */
/*
 * CPU side model: turns a one-cycle fetch command into a vector request
 * and takes the vector at the unit's strobe.
 * Assumes one core clock shared with the unit and the bench.
 */
`timescale 1ns/10ps
`default_nettype none

module cpu_vector_model
(
    input  wire logic        clock,          // Core clock
    input  wire logic        reset,          // Synchronous reset
    input  wire logic        fetch_go,       // Bench asks for one fetch
    input  wire logic        vector_valid,   // Vector strobe from unit
    input  wire logic [15:0] vector_addr,    // Vector from unit
    output logic             vector_request, // Request pulse to unit
    output logic      [15:0] fetched,        // Last vector taken
    output logic             fetch_done      // Vector taken last cycle
);
    // request then take
    // One request pulse per fetch command
    always_ff @(posedge clock)
    begin
        if (reset)
            vector_request <= 1'b0;
        else
            vector_request <= fetch_go;
    end

    // Take the vector only at the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            fetched    <= 16'h0000;
            fetch_done <= 1'b0;
        end
        else
        begin
            fetch_done <= vector_valid;
            if (vector_valid)
                fetched <= vector_addr;
        end
    end
endmodule

`default_nettype wire

/* File: verification/exception_vector_priority_unit_test.sv */
/*
 * Self-checking bench for the exception vector priority unit.
 * Assumes the unit's APB slave and the CPU model share one clock.
 */
`include "evpu_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module exception_vector_priority_unit_test;
    import evpu_pkg::*;
    localparam int NP = 20;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, ext = 1'b0, xpin = 1'b0, i_inh = 1'b0, x_inh = 1'b0;
    logic [NP-1:0] preq = '0;
    fixed_req_t fr = '0;
    cpu_state_t cs = '0;
    logic go = 1'b0, vreq, vval, done, pend, wake;
    logic [15:0] vaddr, fetched;
    logic [15:0] pri [8];
    logic [31:0] q;
    logic er;
    int mismatches = 0, tests_run = 0, cycles = 0;

    exception_vector_priority_unit #(.NUM_PERIPH(NP)) DUT (.clock(clock), .reset(reset),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_req(preq),
        .ext_request_pin(ext), .x_class_request_pin(xpin), .fixed_req(fr),
        .cpu_state(cs), .i_inhibit(i_inh), .x_inhibit(x_inh), .vector_request(vreq),
        .vector_addr(vaddr), .vector_valid(vval), .interrupt_pending(pend),
        .wake_request(wake));

    cpu_vector_model cpu (.clock(clock), .reset(reset), .fetch_go(go), .vector_valid(vval),
        .vector_addr(vaddr), .vector_request(vreq), .fetched(fetched), .fetch_done(done));

    // Clock and cycle ceiling
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(q, {24'h00_0000, e});
    endtask

    task automatic fetch(input logic [15:0] e);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        do
        begin
            @(posedge clock);
        end while (done !== 1'b1);
        check({16'h0000, fetched}, {16'h0000, e});
    endtask

    task automatic flags(input logic p, input logic w);
        repeat (2) @(posedge clock);
        check({30'h0, pend, wake}, {30'h0, p, w});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        pri = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2,
                16'hFF00 + 16'(2 * (NP - 1))};
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(`ADDR_TEST_CONTROL, 8'h00); // reset value
        rd(`ADDR_PROMOTE_SELECT, 8'hF2); // reset value
        apb(1'b0, 8'hF0, 8'h00);
        check({31'h0, er}, 32'h0000_0001); // unmapped refused
        fetch(16'hFFF6); // never pending
        preq[0] <= 1'b1;
        rd(`ADDR_TEST_FORCE_BANK, 8'h00); // normal mode zero
        fr <= 5'h1F;
        xpin <= 1'b1;
        ext <= 1'b1;
        preq[NP-1] <= 1'b1;
        @(posedge clock);
        for (int k = 0; k < 8; k++)
        begin
            fetch(pri[k]); // next winner
            if (k < 5)
                fr[4-k] <= 1'b0;
            else if (k == 5)
                xpin <= 1'b0;
            else if (k == 6)
                ext <= 1'b0;
            else
                preq[NP-1] <= 1'b0;
        end
        fetch(16'hFF00); // lowest slot
        flags(1'b1, 1'b1); // pending shown
        i_inh <= 1'b1;
        flags(1'b0, 1'b0); // I blocked
        fetch(16'hFF00); // last valid
        xpin <= 1'b1;
        x_inh <= 1'b1;
        flags(1'b0, 1'b1); // raw X wakes
        x_inh <= 1'b0;
        fetch(16'hFFF4); // X vector
        cs.x_mask <= 1'b1;
        flags(1'b0, 1'b1); // masked X wakes
        xpin <= 1'b0;
        i_inh <= 1'b0;
        cs.i_mask <= 1'b1;
        apb(1'b1, `ADDR_PROMOTE_SELECT, 8'h10);
        rd(`ADDR_PROMOTE_SELECT, 8'h10); // stored
        cs.i_mask <= 1'b0;
        preq[8] <= 1'b1;
        preq[NP-1] <= 1'b1;
        fetch(16'hFF10); // promoted wins
        apb(1'b1, `ADDR_PROMOTE_SELECT, 8'h40);
        rd(`ADDR_PROMOTE_SELECT, 8'h10); // write needs I mask
        cs.i_mask <= 1'b1;
        apb(1'b1, `ADDR_PROMOTE_SELECT, 8'h40);
        cs.i_mask <= 1'b0;
        fetch(16'hFF00 + 16'(2 * (NP - 1))); // unimplemented ignored
        cs <= '{i_mask: 1'b1, x_mask: 1'b0, special_mode: 1'b1};
        preq <= {{(NP-4){1'b0}}, 4'h8};
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h10);
        rd(`ADDR_TEST_CONTROL, 8'h00); // override kept clear
        cs.x_mask <= 1'b1;
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'hFF);
        rd(`ADDR_TEST_FORCE_BANK, 8'h08); // live inputs, bit map
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h10);
        preq[3] <= 1'b0;
        rd(`ADDR_TEST_FORCE_BANK, 8'h08); // pending kept, inputs cut
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'h01);
        rd(`ADDR_TEST_FORCE_BANK, 8'h01); // forced value
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h1F);
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'hFF);
        rd(`ADDR_TEST_FORCE_BANK, 8'h06); // top bank
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h15);
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'hFF);
        rd(`ADDR_TEST_FORCE_BANK, 8'h00); // missing bank
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h12);
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'hFF);
        rd(`ADDR_TEST_FORCE_BANK, 8'h0F); // partial bank
        cs <= '{i_mask: 1'b0, x_mask: 1'b0, special_mode: 1'b1};
        fetch(16'hFFF4); // forced X with pin low
        apb(1'b1, `ADDR_TEST_FORCE_BANK, 8'h00);
        rd(`ADDR_TEST_FORCE_BANK, 8'h0F); // write needs I mask
        cs.special_mode <= 1'b0;
        apb(1'b1, `ADDR_TEST_CONTROL, 8'h03);
        rd(`ADDR_TEST_CONTROL, 8'h13); // select always, override kept
        rd(`ADDR_TEST_FORCE_BANK, 8'h00); // normal mode zero
        wrap_up();
    end
endmodule

`default_nettype wire
